// ### logic/mtc_top.sv
// translation control, table roots, transparent windows and probe status
// assumes an apb master on sys_clk, an integer unit issuing accesses on
// sys_clk, and an external table walker answering probe walk requests
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module mtc_top
	import mtc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic acc_valid,
	input wire logic [31:0] acc_addr,
	input wire logic space_privilege_bit,
	input wire logic acc_instr,
	input wire logic acc_write,
	input wire logic acc_rmw,
	input wire logic translate_disable_pin,
	output logic res_valid,
	output logic res_translate,
	output logic [31:0] res_root,
	output logic [31:0] res_paddr,
	output logic [1:0] cache_mode,
	output logic res_abort,
	output logic user_attr_out0,
	output logic user_attr_out1,
	output logic page_size_8k,
	input wire logic flush_req,
	output logic flush_translations,
	input wire logic probe_start,
	input wire logic [31:0] probe_addr,
	input wire logic probe_super,
	output logic probe_done,
	output logic walk_req,
	output logic [31:0] walk_root,
	input wire logic walk_done,
	input wire logic walk_bus_err,
	input wire logic walk_valid,
	input wire logic [19:0] walk_paddr,
	input wire logic walk_global,
	input wire logic [1:0] walk_uattr,
	input wire logic walk_super,
	input wire logic [1:0] walk_cm,
	input wire logic walk_mod,
	input wire logic walk_wp_any
);
	import mtc_pkg::*;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [31:0] user_root_pointer_reg;
	logic [31:0] supervisor_table_root_reg;
	logic xlat_enable_reg;
	logic page_size_reg;
	logic [31:0] win_reg [4];
	logic [31:0] probe_status_reg;
	logic [31:0] probe_status_next;
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic translate_disable_pin_meta_reg;
	logic translate_disable_pin_sync_reg;
	mtc_probe_state_t probe_state_reg;
	logic [31:0] probe_addr_reg;
	logic probe_super_reg;
	logic walk_sent_reg;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire logic apb_access = psel & penable;
	wire logic apb_commit = apb_access & pready_reg;
	wire logic apb_wr = apb_commit & pwrite;
	wire logic [3:0] win_sel = (paddr == OFS_DWIN0) ? 4'h1 : (paddr == OFS_DWIN1) ? 4'h2 :
		(paddr == OFS_IWIN0) ? 4'h4 : (paddr == OFS_IWIN1) ? 4'h8 : 4'h0;
	wire logic hit_uroot = paddr == OFS_USER_ROOT;
	wire logic hit_sroot = paddr == OFS_SUPER_ROOT;
	wire logic hit_ctrl = paddr == OFS_XLAT_CTRL;
	wire logic hit_pstat = paddr == OFS_PROBE_STAT;
	wire logic mapped = hit_uroot | hit_sroot | hit_ctrl | hit_pstat | (win_sel != 4'h0);
	wire logic [15:0] ctrl_word = {xlat_enable_reg, page_size_reg, 14'h0000} & CTL_READ_MASK;
	wire logic [31:0] win_rd = win_sel[0] ? win_reg[0] : win_sel[1] ? win_reg[1] :
		win_sel[2] ? win_reg[2] : win_reg[3];
	wire logic [31:0] rd_word = hit_uroot ? user_root_pointer_reg :
		hit_sroot ? supervisor_table_root_reg :
		hit_ctrl ? {16'h0000, ctrl_word} :
		hit_pstat ? probe_status_reg :
		(win_sel != 4'h0) ? (win_rd & WIN_READ_MASK) : RST_WORD;

	// one wait state, so pready and prdata come from flops
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pready_reg <= 1'b0;
			prdata_reg <= RST_WORD;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= apb_access & ~pready_reg;
			prdata_reg <= (apb_access & ~pready_reg & ~pwrite) ? rd_word : RST_WORD;
			pslverr_reg <= apb_access & ~pready_reg & ~mapped;
		end
	end

	// roots stored whole; alignment is software's duty
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			user_root_pointer_reg <= RST_WORD;
			supervisor_table_root_reg <= RST_WORD;
			xlat_enable_reg <= 1'b0;
		end else begin
			if (apb_wr & hit_uroot) begin
				user_root_pointer_reg <= pwdata;
			end
			if (apb_wr & hit_sroot) begin
				supervisor_table_root_reg <= pwdata;
			end
			if (apb_wr & hit_ctrl) begin
				xlat_enable_reg <= pwdata[CTL_ENABLE_BIT];
			end
		end
	end

	// page size has no reset term
	always_ff @(posedge sys_clk) begin
		if (apb_wr & hit_ctrl) begin
			page_size_reg <= pwdata[CTL_PSIZE_BIT];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_win
			always_ff @(posedge sys_clk) begin
				if (!nrst) begin
					win_reg[gi] <= RST_WORD;
				end else if (apb_wr & win_sel[gi]) begin
					win_reg[gi] <= pwdata & WIN_READ_MASK;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// translate-disable pin synchroniser
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			translate_disable_pin_meta_reg <= 1'b0;
			translate_disable_pin_sync_reg <= 1'b0;
		end else begin
			translate_disable_pin_meta_reg <= translate_disable_pin;
			translate_disable_pin_sync_reg <= translate_disable_pin_meta_reg;
		end
	end

	// ----------------------------------------
	// window compares: access path and probe path
	// ----------------------------------------
	logic [3:0] acc_hit;
	logic [3:0] prb_hit;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_match
			mtc_window_match u_acc (
				.win(win_reg[gi]),
				.addr_hi(acc_addr[31:24]),
				.privileged(space_privilege_bit),
				.hit(acc_hit[gi])
			);
			mtc_window_match u_prb (
				.win(win_reg[gi]),
				.addr_hi(probe_addr_reg[31:24]),
				.privileged(probe_super_reg),
				.hit(prb_hit[gi])
			);
		end
	endgenerate

	// instruction fetches use the instruction pair, the rest the data pair
	wire logic [1:0] pair_hit = acc_instr ? acc_hit[3:2] : acc_hit[1:0];
	wire logic [31:0] win_w0 = acc_instr ? win_reg[2] : win_reg[0];
	wire logic [31:0] win_w1 = acc_instr ? win_reg[3] : win_reg[1];
	wire logic [31:0] win_pick = pair_hit[0] ? win_w0 : win_w1;
	wire logic win_any = |pair_hit;
	wire logic paging_on = xlat_enable_reg & ~translate_disable_pin_sync_reg;
	wire logic [1:0] cm_next = win_any ? win_pick[WIN_CM_HI:WIN_CM_LO] : MTC_CM_WT;
	wire logic [1:0] ua_next = win_any ? win_pick[WIN_UATTR_HI:WIN_UATTR_LO] : 2'h0;
	wire logic abort_next = win_any & win_pick[WIN_WPROT_BIT] & (acc_write | acc_rmw);
	wire logic [31:0] root_sel = space_privilege_bit ? supervisor_table_root_reg :
		user_root_pointer_reg;

	// ----------------------------------------
	// access result
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			res_valid <= 1'b0;
			res_translate <= 1'b0;
			res_root <= RST_WORD;
			res_paddr <= RST_WORD;
			cache_mode <= MTC_CM_WT;
			res_abort <= 1'b0;
			user_attr_out0 <= 1'b0;
			user_attr_out1 <= 1'b0;
		end else begin
			res_valid <= acc_valid;
			if (acc_valid) begin
				res_translate <= paging_on & ~win_any;
				res_root <= root_sel;
				res_paddr <= acc_addr;
				cache_mode <= cm_next;
				res_abort <= abort_next;
				user_attr_out0 <= ua_next[0];
				user_attr_out1 <= ua_next[1];
			end
		end
	end

	// flush is only ever raised by the request, never by control writes
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			flush_translations <= 1'b0;
			page_size_8k <= 1'b0;
		end else begin
			flush_translations <= flush_req;
			page_size_8k <= page_size_reg;
		end
	end

	// ----------------------------------------
	// probe sequencing
	// ----------------------------------------
	wire logic prb_win = |prb_hit;
	wire logic prb_root_super = probe_super_reg;
	logic [31:0] desc_word;
	always_comb begin
		desc_word = RST_WORD;
		desc_word[31:PS_PADDR_LO] = walk_paddr;
		desc_word[PS_GLOBAL_BIT] = walk_global;
		desc_word[PS_UATTR_LO +: 2] = walk_uattr;
		desc_word[PS_SUPER_BIT] = walk_super;
		desc_word[PS_CM_LO +: 2] = walk_cm;
		desc_word[PS_MOD_BIT] = walk_mod;
		desc_word[PS_WPROT_BIT] = walk_wp_any;
		desc_word[PS_RESIDENT_BIT] = walk_valid;
	end

	always_comb begin
		probe_status_next = probe_status_reg;
		if (probe_state_reg == MTC_PR_IDLE && apb_wr && hit_pstat) begin
			probe_status_next = pwdata;
		end else if (probe_state_reg == MTC_PR_WALK && prb_win) begin
			probe_status_next = RST_WORD;
			probe_status_next[PS_WINHIT_BIT] = 1'b1;
			probe_status_next[PS_RESIDENT_BIT] = 1'b1;
		end else if (probe_state_reg == MTC_PR_WALK && walk_done && walk_bus_err) begin
			probe_status_next = RST_WORD;
			probe_status_next[PS_BUSERR_BIT] = 1'b1;
		end else if (probe_state_reg == MTC_PR_WALK && walk_done) begin
			probe_status_next = desc_word;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			probe_state_reg <= MTC_PR_IDLE;
			probe_status_reg <= RST_WORD;
			probe_addr_reg <= RST_WORD;
			probe_super_reg <= 1'b0;
			probe_done <= 1'b0;
			walk_req <= 1'b0;
			walk_root <= RST_WORD;
			walk_sent_reg <= 1'b0;
		end else begin
			probe_status_reg <= probe_status_next;
			probe_done <= 1'b0;
			walk_req <= 1'b0;
			case (probe_state_reg)
				MTC_PR_IDLE: begin
					if (probe_start) begin
						probe_addr_reg <= probe_addr;
						probe_super_reg <= probe_super;
						probe_state_reg <= MTC_PR_WALK;
						walk_sent_reg <= 1'b0;
					end
				end
				MTC_PR_WALK: begin
					if (prb_win || walk_done) begin
						probe_done <= 1'b1;
						probe_state_reg <= MTC_PR_IDLE;
					end else if (!walk_sent_reg) begin
						walk_req <= 1'b1;
						walk_sent_reg <= 1'b1;
						walk_root <= prb_root_super ? supervisor_table_root_reg :
							user_root_pointer_reg;
					end
				end
				default: begin
					probe_state_reg <= MTC_PR_IDLE;
				end
			endcase
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence s_ctrl_write;
		apb_wr && hit_ctrl;
	endsequence
	sequence s_ctrl_read;
		psel && penable && !pready_reg && !pwrite && hit_ctrl;
	endsequence

	ctrl_zero_bits_a: assert property (s_ctrl_read |=> prdata[13:0] == 14'h0000 && prdata[31:16] == 16'h0000) else $error("control reserved bits not zero");
	ctrl_enable_a: assert property (s_ctrl_write |=> xlat_enable_reg == $past(pwdata[15])) else $error("enable not written");
	no_flush_a: assert property (!flush_req |=> !flush_translations) else $error("flush without request");
	flush_any_a: assert property (flush_req |=> flush_translations) else $error("flush lost");
	win_zero_bits_a: assert property (psel && penable && !pready_reg && !pwrite && win_sel != 4'h0 |=> (prdata & ~WIN_READ_MASK) == 32'h0) else $error("window reserved bits set");
	default_attr_a: assert property (acc_valid && !win_any |=> cache_mode == MTC_CM_WT && !user_attr_out0 && !user_attr_out1 && !res_abort) else $error("default attributes wrong");
	win_mode_a: assert property (acc_valid && win_any |=> cache_mode == $past(win_pick[6:5]) && !res_translate) else $error("window mode wrong");
	wp_abort_a: assert property (acc_valid && win_any && win_pick[2] && acc_write |=> res_abort) else $error("protected write not aborted");
	root_pick_a: assert property (acc_valid && space_privilege_bit |=> res_root == $past(supervisor_table_root_reg)) else $error("wrong root");
	berr_only_a: assert property (probe_state_reg == MTC_PR_WALK && !prb_win && walk_done && walk_bus_err |=> probe_status_reg == 32'h0000_0800) else $error("bus error status wrong");
	win_probe_a: assert property (probe_state_reg == MTC_PR_WALK && prb_win |=> probe_status_reg == 32'h0000_0003 && probe_done) else $error("window probe status wrong");
endmodule : mtc_top

// ### logic/mtc_pkg.sv
// package for the translation control and transparent window block
// assumes a 32-bit apb register bus and a 100 MHz sys_clk
package mtc_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_USER_ROOT = 8'h00;
	localparam logic [7:0] OFS_SUPER_ROOT = 8'h04;
	localparam logic [7:0] OFS_XLAT_CTRL = 8'h08;
	localparam logic [7:0] OFS_DWIN0 = 8'h0C;
	localparam logic [7:0] OFS_DWIN1 = 8'h10;
	localparam logic [7:0] OFS_IWIN0 = 8'h14;
	localparam logic [7:0] OFS_IWIN1 = 8'h18;
	localparam logic [7:0] OFS_PROBE_STAT = 8'h1C;
	// ----------------------------------------
	// field positions and read masks
	// ----------------------------------------
	localparam int CTL_ENABLE_BIT = 15;
	localparam int CTL_PSIZE_BIT = 14;
	localparam logic [15:0] CTL_READ_MASK = 16'hC000;
	localparam logic [31:0] WIN_READ_MASK = 32'hFFFFE364;
	localparam int WIN_ENABLE_BIT = 15;
	localparam int WIN_PRIV_HI = 14;
	localparam int WIN_PRIV_LO = 13;
	localparam int WIN_UATTR_HI = 9;
	localparam int WIN_UATTR_LO = 8;
	localparam int WIN_CM_HI = 6;
	localparam int WIN_CM_LO = 5;
	localparam int WIN_WPROT_BIT = 2;
	localparam int PS_BUSERR_BIT = 11;
	localparam int PS_GLOBAL_BIT = 10;
	localparam int PS_UATTR_LO = 8;
	localparam int PS_SUPER_BIT = 7;
	localparam int PS_CM_LO = 5;
	localparam int PS_MOD_BIT = 4;
	localparam int PS_WPROT_BIT = 2;
	localparam int PS_WINHIT_BIT = 1;
	localparam int PS_RESIDENT_BIT = 0;
	localparam int PS_PADDR_LO = 12;
	// ----------------------------------------
	// reset values and cache modes
	// ----------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	typedef enum logic [1:0] {
		MTC_CM_WT = 2'h0,
		MTC_CM_CB = 2'h1,
		MTC_CM_NC_SER = 2'h2,
		MTC_CM_NC = 2'h3
	} mtc_cache_mode_t;
	typedef enum logic [1:0] {
		MTC_PR_IDLE = 2'h0,
		MTC_PR_WALK = 2'h1
	} mtc_probe_state_t;
endpackage : mtc_pkg

// ### logic/mtc_window_match.sv
// one transparent window compare
// assumes window word already holds its stored fields
`timescale 1ns/1ps
module mtc_window_match
	import mtc_pkg::*;
(
	input wire logic [31:0] win,
	input wire logic [7:0] addr_hi,
	input wire logic privileged,
	output logic hit
);
	wire logic [7:0] diff = (win[31:24] ^ addr_hi) & ~win[23:16];
	wire logic priv_ok = win[WIN_PRIV_HI] | (win[WIN_PRIV_LO] == privileged);
	assign hit = win[WIN_ENABLE_BIT] & (diff == 8'h00) & priv_ok;
endmodule : mtc_window_match

// ### test/mtc_walker.sv
// table walker model answering the probe logic's walk requests
// assumes walk_req is a one-cycle pulse on sys_clk
`timescale 1ns/1ps
module mtc_walker (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic walk_req,
	input wire logic [3:0] dly,
	input wire logic [31:0] want,
	output logic walk_done,
	output logic [31:0] desc
);
	logic [3:0] cnt_reg;
	logic busy_reg;
	// answer word toggles outside walk_done so a stale sample shows
	always_ff @(posedge sys_clk) begin
		walk_done <= 1'b0;
		desc <= ~desc;
		if (!nrst) begin
			busy_reg <= 1'b0;
			cnt_reg <= 4'h0;
			desc <= 32'h0000_0000;
		end else if (walk_req) begin
			busy_reg <= 1'b1;
			cnt_reg <= dly;
		end else if (busy_reg && cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end else if (busy_reg) begin
			busy_reg <= 1'b0;
			walk_done <= 1'b1;
			desc <= want;
		end
	end
endmodule : mtc_walker

// ### test/mtc_top_tb.sv
// self-checking bench for the translation control block
// assumes mtc_pkg offsets and the walker model beside it
`timescale 1ns/1ps
module mtc_top_tb;
	import mtc_pkg::*;
	logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, acc_addr, res_root, res_paddr, probe_addr, walk_root;
	logic [31:0] want, desc;
	logic acc_valid, space_privilege_bit, acc_instr, acc_write, acc_rmw, translate_disable_pin;
	logic res_valid, res_translate, res_abort, user_attr_out0, user_attr_out1, page_size_8k;
	logic flush_req, flush_translations, probe_start, probe_super, probe_done, walk_req;
	logic walk_done;
	logic [1:0] cache_mode;
	logic [3:0] dly;
	logic [5:0] outs;
	int error_cnt, samples_checked;
	assign outs = {res_translate, res_abort, cache_mode, user_attr_out1, user_attr_out0};
	mtc_top uut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .acc_valid, .acc_addr, .space_privilege_bit, .acc_instr, .acc_write, .acc_rmw,
		.translate_disable_pin, .res_valid, .res_translate, .res_root, .res_paddr, .cache_mode,
		.res_abort, .user_attr_out0, .user_attr_out1, .page_size_8k, .flush_req,
		.flush_translations, .probe_start, .probe_addr, .probe_super, .probe_done, .walk_req,
		.walk_root, .walk_done, .walk_bus_err(desc[11]), .walk_valid(desc[0]),
		.walk_paddr(desc[31:12]), .walk_global(desc[10]), .walk_uattr(desc[9:8]),
		.walk_super(desc[7]), .walk_cm(desc[6:5]), .walk_mod(desc[4]), .walk_wp_any(desc[2]));
	mtc_walker wlk (.sys_clk, .nrst, .walk_req, .dly, .want, .walk_done, .desc);
	// ----------------
	// shared tasks
	// ----------------
	task results();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			error_cnt++;
			results();
		end
	endtask : apb
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, ex, rd);
	endtask : rchk
	task acc(input logic [31:0] a, input logic pv, input logic ins, input logic [1:0] k,
		input logic [5:0] ex);
		@(posedge sys_clk);
		acc_valid <= 1'b1;
		acc_addr <= a;
		space_privilege_bit <= pv;
		acc_instr <= ins;
		acc_write <= k[0];
		acc_rmw <= k[1];
		@(posedge sys_clk);
		acc_valid <= 1'b0;
		@(negedge sys_clk);
		chk("res_valid", 32'h1, {31'h0, res_valid});
		chk("outs", {26'h0, ex}, {26'h0, outs});
	endtask : acc
	task probe(input logic [31:0] a, input logic [31:0] w, input logic [3:0] d,
		input logic [31:0] ex);
		int n;
		want <= w;
		dly <= d;
		@(posedge sys_clk);
		probe_start <= 1'b1;
		probe_addr <= a;
		probe_super <= 1'b1;
		@(posedge sys_clk);
		probe_start <= 1'b0;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (probe_done !== 1'b1 && n < 40);
		if (n >= 40) begin
			error_cnt++;
			results();
		end
		rchk("status", OFS_PROBE_STAT, ex);
	endtask : probe
	// ----------------
	// scenarios
	// ----------------
	task s_regs();
		apb(1'b1, OFS_XLAT_CTRL, 32'hFFFF_FFFF);
		rchk("ctrl", OFS_XLAT_CTRL, 32'h0000_C000);
		chk("page", 32'h1, {31'h0, page_size_8k});
		apb(1'b1, OFS_IWIN0, 32'hFFFF_FFFF);
		rchk("win", OFS_IWIN0, 32'hFFFF_E364);
		apb(1'b1, OFS_IWIN0, 32'h0000_0000);
		apb(1'b1, 8'h20, 32'h0000_0001);
		chk("slverr", 32'h1, {31'h0, err});
	endtask : s_regs
	task s_off_root();
		apb(1'b1, OFS_XLAT_CTRL, 32'h0000_0000);
		acc(32'h1234_5678, 1'b0, 1'b0, 2'h1, 6'h00);
		chk("paddr", 32'h1234_5678, res_paddr);
		apb(1'b1, OFS_USER_ROOT, 32'h0000_1000);
		apb(1'b1, OFS_SUPER_ROOT, 32'h0000_2000);
		apb(1'b1, OFS_XLAT_CTRL, 32'h0000_8000);
		acc(32'h1234_5678, 1'b1, 1'b0, 2'h0, 6'h20);
		chk("root", 32'h0000_2000, res_root);
		acc(32'h1234_5678, 1'b0, 1'b0, 2'h0, 6'h20);
		chk("root", 32'h0000_1000, res_root);
	endtask : s_off_root
	task s_win();
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, OFS_DWIN0, 32'h1200_C000 | (i << 5));
			acc(32'h12AB_0000, 1'b1, 1'b0, 2'h0, 6'(i << 2));
		end
		@(posedge sys_clk);
		translate_disable_pin <= 1'b1;
		apb(1'b1, OFS_DWIN0, 32'h1200_C324);
		acc(32'h1234_5678, 1'b0, 1'b0, 2'h1, 6'h17);
		acc(32'h1234_5678, 1'b0, 1'b0, 2'h2, 6'h17);
		acc(32'h1234_5678, 1'b0, 1'b0, 2'h0, 6'h07);
		acc(32'h1234_5678, 1'b0, 1'b1, 2'h1, 6'h00);
		@(posedge sys_clk);
		translate_disable_pin <= 1'b0;
		apb(1'b1, OFS_DWIN1, 32'h403F_A040);
		acc(32'h7F00_0000, 1'b1, 1'b0, 2'h0, 6'h08);
		acc(32'h7F00_0000, 1'b0, 1'b0, 2'h0, 6'h20);
		acc(32'hC000_0000, 1'b1, 1'b0, 2'h0, 6'h20);
		apb(1'b1, OFS_DWIN0, 32'h1200_4324);
		acc(32'h1234_5678, 1'b0, 1'b0, 2'h1, 6'h20);
		apb(1'b1, OFS_IWIN1, 32'h1200_C160);
		acc(32'h1234_5678, 1'b0, 1'b1, 2'h0, 6'h0D);
	endtask : s_win
	task s_flush();
		apb(1'b1, OFS_XLAT_CTRL, 32'h0000_0000);
		@(posedge sys_clk);
		flush_req <= 1'b1;
		@(posedge sys_clk);
		flush_req <= 1'b0;
		@(negedge sys_clk);
		chk("flush", 32'h1, {31'h0, flush_translations});
	endtask : s_flush
	task s_probe();
		apb(1'b1, OFS_XLAT_CTRL, 32'h0000_8000);
		apb(1'b1, OFS_DWIN0, 32'h1200_C324);
		probe(32'h1200_0000, 32'hABCD_E5D5, 4'h0, 32'h0000_0003);
		probe(32'h8500_0000, 32'hABCD_E5D5, 4'h6, 32'hABCD_E5D5);
		chk("walk_root", 32'h0000_2000, walk_root);
		probe(32'h8500_0000, 32'hABCD_EDD5, 4'h0, 32'h0000_0800);
	endtask : s_probe
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		{nrst, psel, penable, pwrite, acc_valid, space_privilege_bit, acc_instr} = '0;
		{acc_write, acc_rmw, translate_disable_pin, flush_req, probe_start, probe_super} = '0;
		{paddr, pwdata, acc_addr, probe_addr, want, dly} = '0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		s_regs();
		s_off_root();
		s_win();
		s_flush();
		s_probe();
		results();
	end
endmodule : mtc_top_tb
